//--- inc/watchdog_cfg.svh
`ifndef WATCHDOG_CFG_SVH
`define WATCHDOG_CFG_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define WD_CLK_HZ 25000000
`define WD_MS_NS 1000000
`define WD_CLK_NS 40
`define WD_MS_CYCLES (`WD_MS_NS / `WD_CLK_NS)

// ----------------------------------------------------------------
// Times in milliseconds
// ----------------------------------------------------------------
`define WD_T_1S 1000
`define WD_T_2S 2000
`define WD_T_5S 5000
`define WD_T_10S 10000
`define WD_T_30S 30000
`define WD_T_1M 60000
`define WD_T_2M 120000
`define WD_T_5M 300000
`define WD_T_10M 600000
`define WD_T_30M 1800000

// ----------------------------------------------------------------
// Reset values of the configuration ports
// ----------------------------------------------------------------
`define WD_BOOT_TO_RESET 3'h0
`define WD_HOLD_RESET 1'b1
`define WD_ACPI_KIND_RESET 1'b0

`endif

//--- inc/watchdog_pkg.sv
package watchdog_pkg;
   // Boot-phase timeout select
   typedef enum logic [2:0] {
      BOOT_OFF, BOOT_30S, BOOT_1M, BOOT_2M, BOOT_5M, BOOT_10M, BOOT_30M
   } boot_to_t;
   // Runtime operating mode
   typedef enum logic [1:0] {
      MODE_OFF, MODE_ONE_TRIGGER, MODE_SINGLE, MODE_REPEAT
   } run_mode_t;
   // Start delay select
   typedef enum logic [2:0] {
      DLY_NONE, DLY_10S, DLY_30S, DLY_1M, DLY_2M, DLY_5M, DLY_10M, DLY_30M
   } delay_t;
   // Stage action; no NMI choice exists
   typedef enum logic [1:0] {
      ACT_OFF, ACT_ACPI, ACT_RESET, ACT_POWER
   } action_t;
   // Stage timeout select, 1 s .. 30 min
   typedef enum logic [3:0] {
      TO_1S, TO_2S, TO_5S, TO_10S, TO_30S,
      TO_1M, TO_2M, TO_5M, TO_10M, TO_30M
   } stage_to_t;
   // Runtime sequencer states
   typedef enum logic [1:0] {
      RUN_IDLE, RUN_DELAY, RUN_STAGE, RUN_DONE
   } run_state_t;
endpackage

//--- core/staged_watchdog.sv
`include "watchdog_cfg.svh"
module staged_watchdog
   import watchdog_pkg::*;
#(
   parameter int MS_CYCLES = `WD_MS_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic post_running,
   input wire logic user_wait,
   input wire boot_to_t boot_timeout,
   input wire logic hold_on_user,
   input wire run_mode_t run_mode,
   input wire delay_t start_delay,
   input wire action_t action_1,
   input wire action_t action_2,
   input wire action_t action_3,
   input wire stage_to_t timeout_1,
   input wire stage_to_t timeout_2,
   input wire stage_to_t timeout_3,
   input wire logic acpi_restart,
   input wire logic os_start,
   input wire logic trigger,
   output logic sys_reset,
   output logic power_button,
   output logic acpi_overtemp,
   output logic acpi_fatal,
   output logic run_active,
   output logic [1:0] run_stage
);
   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta, rst_sync;
   logic [2:0] pin_meta, pin_sync;
   logic post_s, user_s, trig_s, trig_prev;

   // Release reset through two flops, assert at once
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   // Post, user-wait and trigger pins pass two flops before use; os_start and the settings are used directly
   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         trig_prev <= 1'b0;
      end else begin
         pin_meta <= {trigger, user_wait, post_running};
         pin_sync <= pin_meta;
         trig_prev <= pin_sync[2];
      end
   end
   assign post_s = pin_sync[0];
   assign user_s = pin_sync[1];
   assign trig_s = pin_sync[2] & ~trig_prev;
   // ----------------------------------------------------------------
   // Millisecond tick divider
   // ----------------------------------------------------------------
   logic [31:0] div_cnt, next_div_cnt;
   logic ms_tick, next_ms_tick;
   // One enable pulse per millisecond
   always_comb begin
      next_ms_tick = 1'b0;
      next_div_cnt = div_cnt + 32'h1;
      if (div_cnt >= 32'(MS_CYCLES - 1)) begin
         next_div_cnt = 32'h0;
         next_ms_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         div_cnt <= 32'h0;
         ms_tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         ms_tick <= next_ms_tick;
      end
   end

   // ----------------------------------------------------------------
   // Timeout tables in milliseconds
   // ----------------------------------------------------------------
   function automatic logic [31:0] stage_ms(input stage_to_t sel);
      unique case (sel)
         TO_1S: stage_ms = 32'(`WD_T_1S);
         TO_2S: stage_ms = 32'(`WD_T_2S);
         TO_5S: stage_ms = 32'(`WD_T_5S);
         TO_10S: stage_ms = 32'(`WD_T_10S);
         TO_30S: stage_ms = 32'(`WD_T_30S);
         TO_1M: stage_ms = 32'(`WD_T_1M);
         TO_2M: stage_ms = 32'(`WD_T_2M);
         TO_5M: stage_ms = 32'(`WD_T_5M);
         TO_10M: stage_ms = 32'(`WD_T_10M);
         default: stage_ms = 32'(`WD_T_30M);
      endcase
   endfunction
   function automatic logic [31:0] delay_ms(input delay_t sel);
      unique case (sel)
         DLY_NONE: delay_ms = 32'h0;
         DLY_10S: delay_ms = 32'(`WD_T_10S);
         DLY_30S: delay_ms = 32'(`WD_T_30S);
         DLY_1M: delay_ms = 32'(`WD_T_1M);
         DLY_2M: delay_ms = 32'(`WD_T_2M);
         DLY_5M: delay_ms = 32'(`WD_T_5M);
         DLY_10M: delay_ms = 32'(`WD_T_10M);
         DLY_30M: delay_ms = 32'(`WD_T_30M);
      endcase
   endfunction
   function automatic logic [31:0] boot_ms(input boot_to_t sel);
      unique case (sel)
         BOOT_30S: boot_ms = 32'(`WD_T_30S);
         BOOT_1M: boot_ms = 32'(`WD_T_1M);
         BOOT_2M: boot_ms = 32'(`WD_T_2M);
         BOOT_5M: boot_ms = 32'(`WD_T_5M);
         BOOT_10M: boot_ms = 32'(`WD_T_10M);
         BOOT_30M: boot_ms = 32'(`WD_T_30M);
         default: boot_ms = 32'h0;
      endcase
   endfunction
   // ----------------------------------------------------------------
   // Boot-phase watchdog
   // ----------------------------------------------------------------
   logic [31:0] boot_cnt, next_boot_cnt;
   logic boot_fire;
   // Counts during self test, frozen while the user is asked
   always_comb begin
      next_boot_cnt = boot_cnt;
      boot_fire = 1'b0;
      if (!post_s || boot_timeout == BOOT_OFF) begin
         next_boot_cnt = 32'h0;
      end else if (hold_on_user && user_s) begin
         next_boot_cnt = boot_cnt;
      end else if (ms_tick) begin
         next_boot_cnt = boot_cnt + 32'h1;
         if (boot_cnt + 32'h1 >= boot_ms(boot_timeout)) begin
            boot_fire = 1'b1;
            next_boot_cnt = 32'h0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         boot_cnt <= 32'h0;
      end else begin
         boot_cnt <= next_boot_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Runtime staged watchdog
   // ----------------------------------------------------------------
   run_state_t state, next_state;
   logic [1:0] stage, next_stage;
   logic [31:0] run_cnt, next_run_cnt;
   action_t cur_act, next_fire_act;
   stage_to_t cur_to;
   logic next_fire;
   // Current stage settings; stage 1 is never off
   always_comb begin
      unique case (stage)
         2'h0: begin
            cur_act = (action_1 == ACT_OFF) ? ACT_ACPI : action_1;
            cur_to = timeout_1;
         end
         2'h1: begin
            cur_act = action_2;
            cur_to = timeout_2;
         end
         default: begin
            cur_act = action_3;
            cur_to = timeout_3;
         end
      endcase
   end
   // Sequencer: idle, start delay, stages, done until reset
   always_comb begin
      next_state = state;
      next_stage = stage;
      next_run_cnt = run_cnt;
      next_fire = 1'b0;
      next_fire_act = ACT_OFF;
      unique case (state)
         RUN_IDLE: begin
            if (os_start && run_mode != MODE_OFF) begin
               next_state = RUN_DELAY;
               next_run_cnt = 32'h0;
            end
         end
         RUN_DELAY: begin
            if (run_cnt >= delay_ms(start_delay)) begin
               next_state = RUN_STAGE;
               next_stage = 2'h0;
               next_run_cnt = 32'h0;
            end else if (ms_tick) begin
               next_run_cnt = run_cnt + 32'h1;
            end
         end
         RUN_STAGE: begin
            if (trig_s) begin
               next_stage = 2'h0;
               next_run_cnt = 32'h0;
               if (run_mode == MODE_ONE_TRIGGER) begin
                  next_state = RUN_DONE;
               end
            end else if (ms_tick) begin
               next_run_cnt = run_cnt + 32'h1;
               if (run_cnt + 32'h1 >= stage_ms(cur_to)) begin
                  next_fire = 1'b1;
                  next_fire_act = cur_act;
                  next_run_cnt = 32'h0;
                  // Next enabled stage, else repeat this stage in repeat mode, else sequence end
                  if (stage != 2'h2 &&
                      (stage == 2'h0 ? action_2 : action_3) != ACT_OFF) begin
                     next_stage = stage + 2'h1;
                  end else if (run_mode == MODE_REPEAT) begin
                     next_stage = stage;
                  end else begin
                     next_state = RUN_DONE;
                  end
               end
            end
         end
         RUN_DONE: next_state = RUN_DONE;  // Stays off until system reset
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= RUN_IDLE;
         stage <= 2'h0;
         run_cnt <= 32'h0;
      end else begin
         state <= next_state;
         stage <= next_stage;
         run_cnt <= next_run_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Action outputs, one-cycle pulses from flops
   // ----------------------------------------------------------------
   logic next_reset, next_power, next_otemp, next_fatal;
   // ACPI action maps to overtemp or fatal error; no NMI path
   always_comb begin
      next_reset = boot_fire || (next_fire && next_fire_act == ACT_RESET);
      next_power = next_fire && next_fire_act == ACT_POWER;
      next_otemp = next_fire && next_fire_act == ACT_ACPI
                   && !acpi_restart;
      next_fatal = next_fire && next_fire_act == ACT_ACPI
                   && acpi_restart;
   end

   always_ff @(posedge clk or negedge rst_sync) begin
      if (!rst_sync) begin
         sys_reset <= 1'b0;
         power_button <= 1'b0;
         acpi_overtemp <= 1'b0;
         acpi_fatal <= 1'b0;
         run_active <= 1'b0;
         run_stage <= 2'h0;
      end else begin
         sys_reset <= next_reset;
         power_button <= next_power;
         acpi_overtemp <= next_otemp;
         acpi_fatal <= next_fatal;
         run_active <= (next_state == RUN_STAGE);
         run_stage <= next_stage;
      end
   end

endmodule

//--- bench/wd_checker_sva.sv
module wd_checker
   import watchdog_pkg::*;
#(
   parameter int MS_CYCLES = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic post_running,
   input wire run_mode_t run_mode,
   input wire delay_t start_delay,
   input wire action_t action_2,
   input wire logic acpi_restart,
   input wire logic os_start,
   input wire logic sys_reset,
   input wire logic acpi_overtemp,
   input wire logic acpi_fatal,
   input wire logic power_button,
   input wire logic run_active,
   input wire logic [1:0] run_stage
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   int dly_ms[8] = '{0, 10000, 30000, 60000, 120000, 300000, 600000, 1800000};
   logic armed, next_armed;
   int since_arm, next_since_arm;
   // ----
   // Arming tracker
   // ----
   // Saturates so a long run cannot wrap
   always_comb begin
      next_armed = armed | (os_start & (run_mode != MODE_OFF));
      next_since_arm = since_arm < 2000000000 ? since_arm + 1 : since_arm;
      if (os_start) begin
         next_since_arm = 0;
      end
   end
   // Registers only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         armed <= 1'b0;
         since_arm <= 0;
      end else begin
         armed <= next_armed;
         since_arm <= next_since_arm;
      end
   end
   // ----
   // Assertions
   // ----
   chk_arm_first: assert property (run_active |-> armed)
      else $error("runtime active before arming");
   chk_delay_min: assert property ($rose(run_active) |->
      since_arm >= (dly_ms[start_delay] - 1) * MS_CYCLES)
      else $error("start delay cut short");
   chk_shutdown_kind: assert property (acpi_overtemp |->
      !$past(acpi_restart)) else $error("overtemp in restart mode");
   chk_restart_kind: assert property (acpi_fatal |->
      $past(acpi_restart)) else $error("fatal in shutdown mode");
   chk_stage_range: assert property (run_stage != 2'd3)
      else $error("stage index out of range");
   chk_stage_skip: assert property ($changed(run_stage) &&
      run_stage == 2'd1 |-> $past(action_2) != ACT_OFF)
      else $error("disabled stage entered");
   chk_repeat_hold: assert property (run_mode == MODE_REPEAT &&
      $past(run_mode) == MODE_REPEAT |-> !$fell(run_active))
      else $error("repeat mode stopped");
   chk_boot_idle: assert property ((!armed && !post_running) [*6]
      |=> !sys_reset) else $error("reset outside self test");
   cover property (power_button);
   cover property (acpi_fatal);
   cover property ($rose(run_active));
endmodule

bind staged_watchdog wd_checker #(.MS_CYCLES(MS_CYCLES)) wd_checker_inst (
   .clk, .rst_b, .post_running, .run_mode, .start_delay, .action_2,
   .acpi_restart, .os_start, .sys_reset, .acpi_overtemp, .acpi_fatal,
   .power_button, .run_active, .run_stage);

//--- bench/host_model.sv
module host_model (
   input wire logic clk,
   input wire logic arm_req,
   input wire logic kick_req,
   output logic os_start,
   output logic trigger
);
   timeunit 1ns;
   timeprecision 1ps;
   initial os_start = 1'b0;
   initial trigger = 1'b0;
   // One-cycle arming strobe just before the OS boots
   always @(posedge arm_req) begin
      @(posedge clk);
      #1 os_start = 1'b1;
      @(posedge clk);
      #1 os_start = 1'b0;
   end
   // Kick held 4 clocks so the pin sync cannot miss it
   always @(posedge kick_req) begin
      @(posedge clk);
      #1 trigger = 1'b1;
      repeat (4) @(posedge clk);
      #1 trigger = 1'b0;
   end
endmodule

//--- bench/tb_top.sv
module tb_top
   import watchdog_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, post_running = 1'b0, user_wait = 1'b0;
   boot_to_t boot_timeout = BOOT_OFF;
   run_mode_t run_mode = MODE_OFF;
   delay_t start_delay = DLY_NONE;
   action_t action_1 = ACT_ACPI, action_2 = ACT_OFF, action_3 = ACT_OFF;
   stage_to_t timeout_1 = TO_1S, timeout_2 = TO_1S, timeout_3 = TO_1S;
   logic hold_on_user = 1'b1, acpi_restart = 1'b0, kick = 1'b0, arm = 1'b0;
   logic trigger, os_start, sys_reset, power_button, acpi_overtemp;
   logic acpi_fatal, run_active;
   logic [1:0] run_stage;
   int errors = 0, checks_done = 0, cycles = 0;
   int to_ms[10] = '{1000, 2000, 5000, 10000, 30000, 60000, 120000,
      300000, 600000, 1800000};
   host_model host_model_inst (.clk, .arm_req(arm), .kick_req(kick),
      .os_start, .trigger);
   staged_watchdog #(.MS_CYCLES(1)) staged_watchdog_inst (.clk, .rst_b,
      .post_running, .user_wait, .boot_timeout, .hold_on_user, .run_mode,
      .start_delay, .action_1, .action_2, .action_3, .timeout_1,
      .timeout_2, .timeout_3, .acpi_restart, .os_start, .trigger,
      .sys_reset, .power_button, .acpi_overtemp, .acpi_fatal, .run_active,
      .run_stage);
   // ----
   // Clock, timeout and reporting
   // ----
   always #20 clk = ~clk;
   // Ceiling well above the roughly 60k cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmp_act(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t outputs %h not %h", $time, got, exp);
      end
   endtask
   // Slack covers pin sync and the 1 ms tick phase
   task automatic cmp_time(input int got, input int exp);
      checks_done++;
      if (got < exp - 2 || got > exp + 8) begin
         errors++;
         $display("CHECK FAILED %0t %0d cycles not %0d", $time, got, exp);
      end
   endtask
   task automatic cmp_stage(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t stage %0d not %0d", $time, got, exp);
      end
   endtask
   // ----
   // Reference model
   // ----
   function automatic logic [3:0] act_vec(input action_t a);
      case (a)
         ACT_RESET: return 4'h8;
         ACT_POWER: return 4'h4;
         default: return acpi_restart ? 4'h1 : 4'h2;
      endcase
   endfunction
   task automatic wait_act(input int lim, output int n, output logic [3:0] v);
      n = 0;
      v = 4'h0;
      while (v === 4'h0 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
         v = {sys_reset, power_button, acpi_overtemp, acpi_fatal};
      end
   endtask
   task automatic do_reset();
      #1 rst_b = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic do_arm();
      arm = 1'b1;
      repeat (2) @(posedge clk);
      #1 arm = 1'b0;
   endtask
   // Expected pulses queued in stage order, extra repeats of the last
   task automatic run_seq(input int reps, input int dly);
      action_t acts[3];
      stage_to_t tos[3];
      logic [3:0] q[$];
      int ms[$];
      int n;
      int nst;
      logic [3:0] v;
      acts = '{action_1, action_2, action_3};
      tos = '{timeout_1, timeout_2, timeout_3};
      for (int i = 0; i < 3; i++) begin
         if (i > 0 && acts[i] == ACT_OFF) break;
         q.push_back(act_vec(acts[i]));
         ms.push_back(to_ms[tos[i]]);
      end
      nst = q.size();
      repeat (reps) begin
         q.push_back(q[$]);
         ms.push_back(ms[$]);
      end
      do_arm();
      foreach (q[i]) begin
         wait_act(ms[i] + dly + 20, n, v);
         cmp_act(v, q[i]);
         cmp_time(n, ms[i] + (i == 0 ? dly + 2 : 1));
         cmp_stage(run_stage, 2'(i + 1 < nst ? i + 1 : nst - 1));
      end
   endtask
   // ----
   // Scenarios
   // ----
   initial begin
      int n;
      logic [3:0] v;
      void'($urandom(32'h713c9051));
      do_reset();
      // Arming while the mode is off must leave the runtime side idle
      do_arm();
      // Boot timer: a held pause, then an unheld one that still counts
      boot_timeout = BOOT_30S;
      post_running = 1'b1;
      repeat (1000) @(posedge clk);
      #1 user_wait = 1'b1;
      repeat (500) @(posedge clk);
      #1 user_wait = 1'b0;
      repeat (1000) @(posedge clk);
      #1 user_wait = 1'b1;
      hold_on_user = 1'b0;
      repeat (300) @(posedge clk);
      #1 user_wait = 1'b0;
      wait_act(31000, n, v);
      cmp_act(v, 4'h8);
      cmp_time(n + 2800, 30502);
      cmp_act({3'h0, run_active}, 4'h0);
      hold_on_user = 1'b1;
      post_running = 1'b0;
      do_reset();
      // Single event, all three stages
      run_mode = MODE_SINGLE;
      action_2 = ACT_RESET;
      action_3 = ACT_POWER;
      timeout_2 = stage_to_t'($urandom_range(1, 0));
      timeout_3 = stage_to_t'($urandom_range(1, 0));
      run_seq(0, 0);
      wait_act(3000, n, v);
      cmp_act({v[3:1], run_active}, 4'h0);
      do_reset();
      // Repeat mode, stage 1 left off, restart flavour
      run_mode = MODE_REPEAT;
      acpi_restart = 1'b1;
      action_1 = ACT_OFF;
      action_2 = ACT_POWER;
      action_3 = ACT_OFF;
      timeout_2 = TO_1S;
      run_seq(2, 0);
      do_reset();
      // Start delay, then a kick midway through stage 1
      run_mode = MODE_SINGLE;
      start_delay = DLY_10S;
      action_1 = ACT_RESET;
      do_arm();
      repeat (10000 + $urandom_range(700, 200)) @(posedge clk);
      #1 kick = 1'b1;
      cmp_act({3'h0, run_active}, 4'h1);
      wait_act(2000, n, v);
      kick = 1'b0;
      cmp_act(v, 4'h8);
      cmp_time(n, 1004);
      do_reset();
      // One-time trigger: first kick ends the watchdog
      run_mode = MODE_ONE_TRIGGER;
      start_delay = DLY_NONE;
      action_1 = ACT_POWER;
      do_arm();
      repeat (500) @(posedge clk);
      #1 kick = 1'b1;
      wait_act(2500, n, v);
      kick = 1'b0;
      cmp_act({v[3:1], run_active}, 4'h0);
      test_done();
   end
endmodule
